// file: include/acst_pkg.sv
// Shared constants and types for the conversion sequencer
package acst_pkg;
    // Clock and conversion timing
    localparam int CLK_NS = 25;
    localparam int INT_CONV_NS = 1650;
    localparam int INT_CONV_CYC = INT_CONV_NS / CLK_NS;
    localparam int EOC_MIN_NS = 75;
    localparam int EOC_CYC = (EOC_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int EXT_CONV_TICKS = 13;
    localparam int CNT_W = 8;
    // Sizes
    localparam int NUM_CH = 4;
    localparam int RES_W = 12;
    localparam int FIFO_DEPTH = 16;
    // Reset values and the all-inputs hold mask
    localparam logic [3:0] CHAN_SEL_RST = 4'hF;
    localparam logic [3:0] HOLD_ALL = 4'hF;
    localparam logic [1:0] PTR_FIRST = 2'h0;

    typedef enum logic [2:0] {
        S_IDLE = 3'h1,
        S_CONV = 3'h2,
        S_EOC = 3'h4
    } acst_state_t;

    // Host pins sampled by the device
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [3:0] wdata;
    } acst_bus_in_t;

    // Host data pins driven by the device
    typedef struct packed {
        logic [RES_W-1:0] rdata;
        logic oe;
    } acst_bus_out_t;

    function automatic logic [2:0] acst_popcnt(input logic [3:0] m);
        acst_popcnt = {2'h0, m[0]} + {2'h0, m[1]} + {2'h0, m[2]} + {2'h0, m[3]};
    endfunction
endpackage

// file: core/acst_fifo.sv
// Result FIFO between the converter and the host read port
`timescale 1ns/1ps
module acst_fifo
    import acst_pkg::*;
#(
    parameter int WIDTH = RES_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    // Honest flags straight from the occupancy count
    assign in_ready = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data = mem[rd_ptr_ff];

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    // Pointers wrap because DEPTH is a power of two
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            wr_ptr_ff <= wr_ptr_ff + AW'(push);
            rd_ptr_ff <= rd_ptr_ff + AW'(pop);
            count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// file: core/acst_sequencer.sv
// Conversion sequencer with host read/write port and result FIFO
// What this block and its host do
// [R1] With the external clock chosen, each channel conversion takes exactly 13 of its rising edges.
// [R2] Busy lasts channel count times (conversion plus end pulse) minus one end pulse.
// [R3] The host waits 2 us (external reference) or up to 6 ms (internal) after wake before start.
// [R4] Busy rises no later than 70 ns after the convert start rising edge.
// [R5] Each read strobe rising edge updates the first-result flag within 70 ns.
// [R6] Each end-of-conversion falling edge drives the first-result flag low within 15 ns.
// [R7] Write data is sampled at the write strobe rising edge, valid 5 ns either side.
// [R8] The host leaves at least 10 ns between the end of one read and the next.
// [R9] Busy goes high at convert start and stays high until all selected channels are done.
// [R10] The first-result flag is high only while the pointer addresses the first result.
// [R11] Convert start holds all four inputs, starts the sequence and latches the selection.
// [R12] A write rise with chip select low and read high loads the low four data bits as selection.
// [R13] A synchronous host rounds each minimum wait up to whole cycles and counts them.
`timescale 1ns/1ps
module acst_sequencer
    import acst_pkg::*;
#(
    parameter int FIFO_W = RES_W,
    parameter int FIFO_D = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Conversion control
    input wire logic convert_start,
    input wire logic low_power_request,
    output logic busy,
    output logic eoc_n,
    output logic first_result_flag,
    output logic [3:0] track_hold,
    // Channel selection source
    input wire logic sw_select,
    input wire logic [3:0] hw_channel_sel,
    // Conversion clock choice
    input wire logic use_ext_clock,
    input wire logic external_clock_input,
    // Converter core result
    input wire logic [RES_W-1:0] conv_result,
    // Host parallel bus
    input wire acst_bus_in_t bus_in,
    output acst_bus_out_t bus_out
);
    acst_state_t state_ff;
    acst_state_t nxt_state;
    logic conv_prev_ff;
    logic rd_prev_ff;
    logic wr_prev_ff;
    logic cs_prev_ff;
    logic ext_prev_ff;
    logic [3:0] wdata_prev_ff;
    logic [3:0] chan_sel_ff;
    logic [3:0] remain_ff;
    logic [2:0] seq_n_ff;
    logic use_ext_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic busy_ff;
    logic eoc_n_ff;
    logic flag_ff;
    logic [1:0] ptr_ff;
    logic [3:0] hold_ff;
    logic [RES_W-1:0] rdata_ff;
    logic oe_ff;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [RES_W-1:0] fifo_out_data;

    // Edge detection on synchronous pin samples
    wire start_rise = convert_start & ~conv_prev_ff;
    wire ext_tick = external_clock_input & ~ext_prev_ff;
    wire rd_rise = bus_in.rd_n & ~rd_prev_ff & ~cs_prev_ff;
    wire rd_active = ~bus_in.cs_n & ~bus_in.rd_n;
    wire rd_begin = rd_active & ~(~cs_prev_ff & ~rd_prev_ff);
    // Data, chip select and read strobe from the prior sample, so 5 ns hold suffices
    wire wr_take = bus_in.wr_n & ~wr_prev_ff & ~cs_prev_ff & rd_prev_ff; // [R7] [R12]

    wire [3:0] sel_mask = sw_select ? chan_sel_ff : hw_channel_sel;
    // Standby blocks new sequences; an empty selection starts nothing
    wire start_take = start_rise & (state_ff == S_IDLE) & low_power_request
        & (sel_mask != 4'h0); // [R11]

    // Lowest pending channel converts next
    wire [3:0] cur_bit = remain_ff & (~remain_ff + 4'h1);
    wire [3:0] rest_mask = remain_ff & ~cur_bit;
    wire last_ch = (rest_mask == 4'h0);

    wire ext_end = (cnt_ff == CNT_W'(EXT_CONV_TICKS)); // [R1]
    wire int_end = (cnt_ff == CNT_W'(INT_CONV_CYC - 1));
    wire at_end = use_ext_ff ? ext_end : int_end;
    // A full FIFO stalls the end of a conversion
    wire conv_done = (state_ff == S_CONV) & at_end & fifo_in_ready;
    wire eoc_end = (state_ff == S_EOC) & (cnt_ff == CNT_W'(EOC_CYC - 1));
    wire cnt_step = use_ext_ff ? ext_tick : 1'b1;

    wire ptr_wrap = ({1'b0, ptr_ff} + 3'h1) >= seq_n_ff;
    wire [1:0] nxt_ptr = ptr_wrap ? PTR_FIRST : ptr_ff + 2'h1;
    wire pop_take = rd_rise & fifo_out_valid;

    always_comb begin
        case (state_ff)
            S_IDLE: nxt_state = start_take ? S_CONV : S_IDLE;
            S_CONV: nxt_state = conv_done ? S_EOC : S_CONV;
            S_EOC: nxt_state = eoc_end ? (remain_ff != 4'h0 ? S_CONV : S_IDLE) : S_EOC;
            default: nxt_state = S_IDLE;
        endcase
    end

    // Pin sampling
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_prev_ff <= 1'b0;
            rd_prev_ff <= 1'b1;
            wr_prev_ff <= 1'b1;
            cs_prev_ff <= 1'b1;
            ext_prev_ff <= 1'b0;
            wdata_prev_ff <= 4'h0;
        end else begin
            conv_prev_ff <= convert_start;
            rd_prev_ff <= bus_in.rd_n;
            wr_prev_ff <= bus_in.wr_n;
            cs_prev_ff <= bus_in.cs_n;
            ext_prev_ff <= external_clock_input;
            wdata_prev_ff <= bus_in.wdata;
        end
    end

    // Channel select register
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            chan_sel_ff <= CHAN_SEL_RST;
        end else if (wr_take) begin
            chan_sel_ff <= wdata_prev_ff; // [R12]
        end
    end

    // Sequence state and counters
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= S_IDLE;
            cnt_ff <= '0;
            remain_ff <= 4'h0;
            seq_n_ff <= 3'h0;
            use_ext_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (start_take) begin
                remain_ff <= sel_mask; // [R11]
                seq_n_ff <= acst_popcnt(sel_mask);
                use_ext_ff <= use_ext_clock;
            end else if (conv_done) begin
                remain_ff <= rest_mask;
            end
            if (start_take || conv_done || eoc_end) begin
                cnt_ff <= '0;
            end else if ((state_ff == S_CONV) && !at_end && cnt_step) begin
                cnt_ff <= cnt_ff + CNT_W'(1); // [R1]
            end else if (state_ff == S_EOC) begin
                cnt_ff <= cnt_ff + CNT_W'(1);
            end
        end
    end

    // Busy, end pulse and track-and-hold control
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_ff <= 1'b0;
            eoc_n_ff <= 1'b1;
            hold_ff <= 4'h0;
        end else begin
            if (start_take) begin
                busy_ff <= 1'b1; // [R4] [R9]
                hold_ff <= HOLD_ALL; // [R11]
            end else if (conv_done && last_ch) begin
                busy_ff <= 1'b0; // [R2] [R9]
                hold_ff <= 4'h0;
            end
            if (conv_done) begin
                eoc_n_ff <= 1'b0;
            end else if (eoc_end) begin
                eoc_n_ff <= 1'b1; // [R2]
            end
        end
    end

    // Output pointer and first-result flag
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ptr_ff <= PTR_FIRST;
            flag_ff <= 1'b1;
        end else begin
            if (start_take) begin
                ptr_ff <= PTR_FIRST;
            end else if (rd_rise) begin
                ptr_ff <= nxt_ptr;
            end
            // Same edge as the end pulse falls, so no extra delay
            if (conv_done) begin
                flag_ff <= 1'b0; // [R6]
            end else if (rd_rise) begin
                flag_ff <= ptr_wrap; // [R5] [R10]
            end
        end
    end

    // Read data from flip-flops, loaded as the read opens
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_ff <= '0;
            oe_ff <= 1'b0;
        end else begin
            oe_ff <= rd_active;
            if (rd_begin) begin
                rdata_ff <= fifo_out_data;
            end
        end
    end

    acst_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_D)
    ) u_fifo (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .in_valid(conv_done),
        .in_ready(fifo_in_ready),
        .in_data(conv_result),
        .out_valid(fifo_out_valid),
        .out_ready(pop_take),
        .out_data(fifo_out_data)
    );

    assign busy = busy_ff;
    assign eoc_n = eoc_n_ff;
    assign first_result_flag = flag_ff;
    assign track_hold = hold_ff;
    assign bus_out.rdata = rdata_ff;
    assign bus_out.oe = oe_ff;

    // Checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    logic [9:0] busy_len_ff;
    logic stall_ff;
    logic [3:0] ticks_ff;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_len_ff <= '0;
            stall_ff <= 1'b0;
            ticks_ff <= 4'h0;
        end else begin
            busy_len_ff <= busy_ff ? busy_len_ff + 10'h001 : 10'h000;
            if (start_take) begin
                stall_ff <= 1'b0;
            end else if ((state_ff == S_CONV) && at_end && !fifo_in_ready) begin
                stall_ff <= 1'b1;
            end
            if (state_ff != S_CONV) begin
                ticks_ff <= 4'h0;
            end else if (ext_tick && ticks_ff != 4'hF) begin
                ticks_ff <= ticks_ff + 4'h1;
            end
        end
    end

    property p_ext_conv;
        conv_done && use_ext_ff |-> ticks_ff == 4'(EXT_CONV_TICKS);
    endproperty
    a_ext_conv: assert property (p_ext_conv) else $error("external conversion length wrong"); // [R1]

    property p_busy_len;
        $fell(busy_ff) && !use_ext_ff && !stall_ff
            |-> busy_len_ff == 10'(seq_n_ff * (INT_CONV_CYC + EOC_CYC) - EOC_CYC);
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong"); // [R2]

    property p_busy_rise;
        start_take |=> busy_ff && state_ff == S_CONV;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy late after start"); // [R4]

    property p_flag_rd;
        rd_rise && ptr_wrap && !conv_done |=> first_result_flag && ptr_ff == PTR_FIRST;
    endproperty
    a_flag_rd: assert property (p_flag_rd) else $error("flag not raised on wrap"); // [R5]

    property p_flag_eoc;
        $fell(eoc_n_ff) |-> !first_result_flag;
    endproperty
    a_flag_eoc: assert property (p_flag_eoc) else $error("flag high at end pulse"); // [R6]

    property p_wr_load;
        wr_take |=> chan_sel_ff == $past(wdata_prev_ff);
    endproperty
    a_wr_load: assert property (p_wr_load) else $error("channel select not loaded"); // [R7]

    property p_busy_span;
        busy_ff |-> state_ff != S_IDLE && remain_ff != 4'h0;
    endproperty
    a_busy_span: assert property (p_busy_span) else $error("busy without pending work"); // [R9]

    property p_flag_ptr;
        first_result_flag |-> ptr_ff == PTR_FIRST;
    endproperty
    a_flag_ptr: assert property (p_flag_ptr) else $error("flag high off first result"); // [R10]

    property p_hold;
        start_take |=> (track_hold == HOLD_ALL) [*2];
    endproperty
    a_hold: assert property (p_hold) else $error("inputs not held at start"); // [R11]

    property p_wr_ignored;
        bus_in.wr_n && !wr_prev_ff && (cs_prev_ff || !rd_prev_ff) |=> $stable(chan_sel_ff);
    endproperty
    a_wr_ignored: assert property (p_wr_ignored) else $error("write taken while deselected"); // [R12]

    c_start: cover property (start_take);
    c_four_ch: cover property ($fell(busy_ff) && seq_n_ff == 3'h4);
    c_write: cover property (wr_take);
    c_stall: cover property ((state_ff == S_CONV) && at_end && !fifo_in_ready);
endmodule

// file: testbench/acst_host_model.sv
// Host model driving the parallel bus and the conversion control pins
`timescale 1ns/1ps
module acst_host_model
    import acst_pkg::*;
#(
    parameter int WAKE_NS = 2000
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Device pins
    output acst_bus_in_t bus_in,
    input wire acst_bus_out_t bus_out,
    output logic convert_start,
    output logic low_power_request
);
    // Rounded up so the wait is never short
    localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;

    initial begin
        bus_in = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, wdata: 4'h0};
        convert_start = 1'b0;
        low_power_request = 1'b1;
    end

    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask

    // Data held a full cycle past the strobe rise
    task automatic write_sel(input logic cs_n, input logic [3:0] d);
        tick();
        bus_in.cs_n = cs_n;
        bus_in.wr_n = 1'b0;
        bus_in.wdata = d;
        tick();
        bus_in.wr_n = 1'b1;
        tick();
        bus_in.cs_n = 1'b1;
        bus_in.wdata = ~d;
    endtask

    task automatic read_word(output logic [RES_W-1:0] d);
        tick();
        bus_in.cs_n = 1'b0;
        bus_in.rd_n = 1'b0;
        tick();
        d = bus_out.rdata;
        bus_in.rd_n = 1'b1;
        bus_in.cs_n = 1'b1;
        tick();
    endtask

    task automatic pulse_start();
        tick();
        convert_start = 1'b1;
        tick();
        convert_start = 1'b0;
    endtask

    task automatic sleep();
        tick();
        low_power_request = 1'b0;
    endtask

    task automatic wake();
        tick();
        low_power_request = 1'b1;
        repeat (WAKE_CYC) tick();
    endtask
endmodule

// file: testbench/test_adc_conversion_sequencer_timing.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module test_adc_conversion_sequencer_timing;
    import acst_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic sw_select = 1'b1;
    logic [3:0] hw_channel_sel = 4'h0;
    logic use_ext_clock = 1'b0;
    logic external_clock_input = 1'b0;
    logic ext_run = 1'b0;
    logic [RES_W-1:0] conv_result = 12'h000;
    logic convert_start, low_power_request, busy, eoc_n, first_result_flag;
    logic [3:0] track_hold;
    acst_bus_in_t bus_in;
    acst_bus_out_t bus_out;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc;

    always #12.5 ref_clk = ~ref_clk;
    // External clock, 100 ns period, only while a test asks for it
    always begin
        repeat (2) @(posedge ref_clk);
        #1;
        if (ext_run) begin
            external_clock_input = ~external_clock_input;
        end
    end

    acst_sequencer u_acst_sequencer (
        .ref_clk(ref_clk), .reset_n(reset_n),
        .convert_start(convert_start), .low_power_request(low_power_request),
        .busy(busy), .eoc_n(eoc_n), .first_result_flag(first_result_flag),
        .track_hold(track_hold), .sw_select(sw_select), .hw_channel_sel(hw_channel_sel),
        .use_ext_clock(use_ext_clock), .external_clock_input(external_clock_input),
        .conv_result(conv_result), .bus_in(bus_in), .bus_out(bus_out)
    );

    acst_host_model u_acst_host_model (
        .ref_clk(ref_clk), .reset_n(reset_n), .bus_in(bus_in), .bus_out(bus_out),
        .convert_start(convert_start), .low_power_request(low_power_request)
    );

    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t ns: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Start a sequence, count busy cycles and end-pulse low cycles
    task automatic run_seq(input int n, output int c);
        int lows;
        u_acst_host_model.pulse_start();
        check(16'(busy), 16'h1);
        check(16'(track_hold), 16'(HOLD_ALL));
        c = 0;
        lows = 0;
        while (busy === 1'b1 && c < 2000) begin
            c++;
            if (eoc_n === 1'b0) lows++;
            tick();
        end
        check(16'(first_result_flag), 16'h0);
        repeat (4) begin
            if (eoc_n === 1'b0) lows++;
            tick();
        end
        check(16'(lows), 16'(n * EOC_CYC));
        check(16'(track_hold), 16'h0);
    endtask

    // Flag must stay low until the last read wraps the pointer
    task automatic drain(input int n, input logic [RES_W-1:0] exp);
        logic [RES_W-1:0] d;
        for (int i = 0; i < n; i++) begin
            u_acst_host_model.read_word(d);
            check(16'(d), 16'(exp));
            check(16'(first_result_flag), 16'(i == n - 1));
        end
    endtask

    function automatic int busy_len(input int n);
        return n * (INT_CONV_CYC + EOC_CYC) - EOC_CYC;
    endfunction

    task automatic t_reset();
        check(16'(busy), 16'h0);
        check(16'(eoc_n), 16'h1);
        check(16'(first_result_flag), 16'h1);
        check(16'({track_hold, bus_out.oe}), 16'h0);
        $display("test reset done");
    endtask

    task automatic t_standby();
        u_acst_host_model.sleep();
        u_acst_host_model.pulse_start();
        tick();
        check(16'(busy), 16'h0);
        u_acst_host_model.wake();
        $display("test standby done");
    endtask

    task automatic t_sw_two();
        conv_result = 12'hA51;
        u_acst_host_model.write_sel(1'b0, 4'h5);
        run_seq(2, cyc);
        check(16'(cyc), 16'(busy_len(2)));
        drain(2, 12'hA51);
        $display("test two channels done");
    endtask

    // Second write lacks chip select and must not land
    task automatic t_refused();
        conv_result = 12'h3C6;
        u_acst_host_model.write_sel(1'b0, 4'hB);
        u_acst_host_model.write_sel(1'b1, 4'h1);
        run_seq(3, cyc);
        check(16'(cyc), 16'(busy_len(3)));
        drain(3, 12'h3C6);
        $display("test refused write done");
    endtask

    task automatic t_hw_four();
        conv_result = 12'h5E7;
        sw_select = 1'b0;
        hw_channel_sel = 4'hF;
        run_seq(4, cyc);
        check(16'(cyc), 16'(busy_len(4)));
        drain(4, 12'h5E7);
        $display("test four channels done");
    endtask

    // First external edge lands one to four cycles after start
    task automatic t_ext();
        conv_result = 12'h1D8;
        hw_channel_sel = 4'h2;
        use_ext_clock = 1'b1;
        ext_run = 1'b1;
        run_seq(1, cyc);
        check(16'(cyc >= EXT_CONV_TICKS * 4 - 2 && cyc <= EXT_CONV_TICKS * 4 + 1), 16'h1);
        ext_run = 1'b0;
        use_ext_clock = 1'b0;
        drain(1, 12'h1D8);
        $display("test external clock done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        repeat (2) tick();
        t_reset();
        t_standby();
        t_sw_two();
        t_refused();
        t_hw_four();
        t_ext();
        end_of_test();
    end

    // Whole run needs well under 2000 cycles
    initial begin
        #200000;
        n_mismatch++;
        end_of_test();
    end
endmodule
